/* core/standby_mode_controller.sv */
// Purpose: decodes halt operands and runs stop / halt standby entry and exit
// Assumes: cpu sequencer pulses halt_req once per halt instruction
// Notes:   pclk keeps toggling in simulation; osc_stop_reg models the stop
`default_nettype none

module standby_mode_controller (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu instruction sequencer
    input wire logic halt_req,
    input wire logic [3:0] halt_operand,
    input wire logic flag_set_req,
    input wire logic flag_clear_req,
    input wire logic [3:0] key_scan_lines,
    output logic cpu_hold,
    output logic state_retain,
    output logic status_flag,
    output logic internal_reset,
    output logic resume_next,
    output logic resume_zero,
    // timer
    input wire logic timer_zero,
    input wire logic timer_output_enable,
    output logic timer_clear,
    // pins
    input wire logic [3:0] key_input_pins,
    input wire logic sense_pin_zero,
    input wire logic sense_pin_one,
    input wire logic reset_pin_n,
    output logic osc_stop,
    output logic osc_pins_low,
    output logic osc_wake_level
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    pin_sync_if sync ();
    standby_pkg::standby_state_t state_reg; // current mode
    standby_pkg::standby_state_t state_next;
    logic [3:0] op_reg;        // operand latched at each halt in run
    logic [1:0] sense_mode_reg; // ctrl: sense pins in input mode
    logic flag_reg;            // standby gate status flag
    logic flag_next;
    logic wake_rst_reg;        // last exit came from reset pin
    logic [7:0] rst_cnt_reg;   // refused halts seen in run
    logic [standby_pkg::WAIT_W-1:0] wait_cnt_reg;
    logic rst_pin_d_reg;       // clean reset pin, one cycle late
    logic cpu_hold_reg, retain_reg, int_rst_reg, res_next_reg, res_zero_reg;
    logic tclr_reg, osc_stop_reg, osc_low_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic sel_stop, sel_halt, pre_ok, bad_req, req_wake;
    logic key_any, sense_any, stop_wake, pin_reset;
    logic timer_busy, wait_done, apb_write;
    logic [2:0] op_low;

    // ------------------------------------------------------------
    // pin filtering
    // ------------------------------------------------------------
    assign sync.raw = {reset_pin_n, sense_pin_one, sense_pin_zero, key_input_pins};
    // keys always wake stop; sense pins only with operand bit3 set
    assign sync.wake_mask = {1'b0, sense_mode_reg & {2{op_reg[standby_pkg::OP_SENSE_BIT]}}, 4'hf};

    pin_wake_sync u_sync (
        .pclk (pclk),
        .presetn (presetn),
        .sync (sync)
    );

    // ------------------------------------------------------------
    // operand decode and wake conditions
    // ------------------------------------------------------------
    always_comb begin
        op_low = halt_operand[2:0];
        // RULE10 codes 000 and 011
        sel_stop = (op_low == standby_pkg::OP_STOP_ALL_A) || (op_low == standby_pkg::OP_STOP_ALL_B);
        pre_ok = &key_scan_lines;
        // RULE11 code 110, one scan line
        if (op_low == standby_pkg::OP_STOP_LOW) begin
            sel_stop = 1'b1;
            pre_ok = key_scan_lines[0];
        end
        // RULE13 code 101, bit3 ignored
        sel_halt = (op_low == standby_pkg::OP_HALT_TIMER);
        if (sel_halt) begin
            pre_ok = 1'b1;
        end
        // RULE14 illegal code or unmet precondition
        bad_req = !(sel_stop || sel_halt) || !pre_ok;
    end

    // key wake: any key pin high
    assign key_any = |sync.clean[standby_pkg::NUM_KEYS-1:0];
    // RULE12 sense pins in input mode only
    assign sense_any = |(sync.clean[standby_pkg::SYNC_SENSE_LO +: 2] & sense_mode_reg);
    // wake for the latched operand, used while in stop or wait
    assign stop_wake = key_any || (op_reg[standby_pkg::OP_SENSE_BIT] && sense_any);
    // wake for the incoming operand, checked at the halt itself
    assign req_wake = sel_halt ? timer_zero
                    : (key_any || (halt_operand[standby_pkg::OP_SENSE_BIT] && sense_any));
    // RULE15 timer still counting or enabled
    assign timer_busy = !timer_zero || timer_output_enable;
    assign wait_done = (wait_cnt_reg == standby_pkg::WAIT_W'(standby_pkg::OSC_WAIT_CYCLES - 1));
    // reset pin falling edge on the clean level
    assign pin_reset = rst_pin_d_reg && !sync.clean[standby_pkg::SYNC_RESET_PIN];
    assign apb_write = psel && penable && pready_reg && pwrite;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            standby_pkg::ST_RUN: begin
                // RULE5 entry only from a clear flag
                if (halt_req && !bad_req && !flag_reg && !req_wake) begin
                    if (sel_halt) begin
                        state_next = standby_pkg::ST_HALT;
                    end else if (timer_busy) begin
                        state_next = standby_pkg::ST_DRAIN;
                    end else begin
                        state_next = standby_pkg::ST_STOP;
                    end
                end
            end
            standby_pkg::ST_DRAIN: begin
                // RULE15 stop only once timer is cleared
                if (!timer_busy) begin
                    state_next = standby_pkg::ST_STOP;
                end
            end
            standby_pkg::ST_STOP: begin
                if (stop_wake) begin
                    state_next = standby_pkg::ST_WAIT;
                end
            end
            standby_pkg::ST_WAIT: begin
                // RULE16 wake must still hold when the wait ends
                if (wait_done) begin
                    state_next = stop_wake ? standby_pkg::ST_RUN : standby_pkg::ST_STOP;
                end
            end
            standby_pkg::ST_HALT: begin
                // RULE13 timer zero ends halt
                if (timer_zero) begin
                    state_next = standby_pkg::ST_RUN;
                end
            end
        endcase
        // RULE9 reset pin always returns to run
        if (pin_reset) begin
            state_next = standby_pkg::ST_RUN;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= standby_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // operand latched on every halt while running; selects wake sources while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= 4'h0;
        end else if (state_reg == standby_pkg::ST_RUN && halt_req) begin
            op_reg <= halt_operand;
        end
    end

    // oscillator wait counter, runs only in the wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_reg <= '0;
        end else if (state_reg == standby_pkg::ST_WAIT && !wait_done) begin
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
        end else begin
            wait_cnt_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // status flag
    // ------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        // software clear loses to any hardware set below
        if (flag_clear_req) begin
            flag_next = 1'b0;
        end
        if (state_reg == standby_pkg::ST_RUN && halt_req && !bad_req) begin
            if (flag_reg) begin
                // RULE7 flag follows the wake condition
                flag_next = req_wake;
            end else if (req_wake) begin
                // RULE8 already awake, skip and set
                flag_next = 1'b1;
            end
        end
        // RULE6 exit from standby sets the flag
        if (state_reg != standby_pkg::ST_RUN && state_next == standby_pkg::ST_RUN) begin
            flag_next = 1'b1;
        end
        if (flag_set_req) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_hold_reg <= 1'b0;
            retain_reg <= 1'b0;
            tclr_reg <= 1'b0;
            osc_stop_reg <= 1'b0;
            osc_low_reg <= 1'b0;
        end else begin
            // RULE2 cpu held in any standby state
            cpu_hold_reg <= (state_next != standby_pkg::ST_RUN);
            // RULE3 freeze memory, accumulator, carry, ports
            retain_reg <= (state_next != standby_pkg::ST_RUN);
            // RULE4 timer cleared while draining or stopped
            tclr_reg <= (state_next == standby_pkg::ST_DRAIN) || (state_next == standby_pkg::ST_STOP);
            // RULE1 oscillator off, its pins low
            osc_stop_reg <= (state_next == standby_pkg::ST_STOP);
            osc_low_reg <= (state_next == standby_pkg::ST_STOP);
        end
    end

    // one-cycle pulses toward the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_rst_reg <= 1'b0;
            res_next_reg <= 1'b0;
            res_zero_reg <= 1'b0;
        end else begin
            // RULE14 internal reset on a bad halt
            int_rst_reg <= (state_reg == standby_pkg::ST_RUN) && halt_req && bad_req && !pin_reset;
            // RULE9 resume after halt, or at address zero
            res_next_reg <= !pin_reset && state_reg != standby_pkg::ST_RUN
                            && state_next == standby_pkg::ST_RUN;
            res_zero_reg <= pin_reset;
        end
    end

    // reset pin edge history and exit cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_pin_d_reg <= 1'b1;
            wake_rst_reg <= 1'b0;
            rst_cnt_reg <= 8'h00;
        end else begin
            rst_pin_d_reg <= sync.clean[standby_pkg::SYNC_RESET_PIN];
            if (state_reg != standby_pkg::ST_RUN && state_next == standby_pkg::ST_RUN) begin
                wake_rst_reg <= pin_reset;
            end
            if (state_reg == standby_pkg::ST_RUN && halt_req && bad_req) begin
                rst_cnt_reg <= rst_cnt_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait state, read data captured at setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            if (psel && !penable) begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h0000_0000;
                unique case (paddr)
                    standby_pkg::ADDR_CTRL: prdata_reg[1:0] <= sense_mode_reg;
                    standby_pkg::ADDR_STATUS: begin
                        prdata_reg[4:0] <= state_reg;
                        prdata_reg[standby_pkg::STATUS_FLAG_BIT] <= flag_reg;
                        prdata_reg[standby_pkg::STATUS_WAKE_RST_BIT] <= wake_rst_reg;
                        prdata_reg[standby_pkg::STATUS_OP_LO +: 4] <= op_reg;
                    end
                    standby_pkg::ADDR_RESET_CNT: prdata_reg[7:0] <= rst_cnt_reg;
                    // unmapped: error with zero data
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    // control register: which sense pins are in input mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_mode_reg <= standby_pkg::CTRL_RESET_VAL;
        end else if (apb_write && paddr == standby_pkg::ADDR_CTRL) begin
            sense_mode_reg <= pwdata[standby_pkg::CTRL_SENSE_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // output wiring
    // ------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_hold = cpu_hold_reg;
    assign state_retain = retain_reg;
    assign status_flag = flag_reg;
    assign internal_reset = int_rst_reg;
    assign resume_next = res_next_reg;
    assign resume_zero = res_zero_reg;
    assign timer_clear = tclr_reg;
    assign osc_stop = osc_stop_reg;
    assign osc_pins_low = osc_low_reg;
    // unclocked by design: it must act while the oscillator is off
    assign osc_wake_level = sync.wake_raw && osc_stop_reg;

endmodule

`default_nettype wire

/* inc/standby_pkg.sv */
// Purpose: shared constants and types of the standby mode controller
// Assumes: 40 MHz pclk, APB slave with 32-bit data
// Notes:   operand codes, register map and wait timing live here
//
// Behaviour
// RULE1: stop mode halts oscillator, pins held low
// RULE2: halt mode stops cpu, clock keeps running
// RULE3: standby preserves memory, accumulator, carry, ports
// RULE4: timer count forced to zero during stop
// RULE5: entry only by halt with flag clear
// RULE6: leaving standby sets the status flag
// RULE7: flag set: no entry, flag follows wake
// RULE8: wake already true: skip entry, set flag
// RULE9: reset resumes at zero, wake continues
// RULE10: codes 000/011 stop, all scan lines high
// RULE11: code 110 stop, lowest scan line high
// RULE12: operand bit3 adds sense pin wake
// RULE13: code 101 halt until timer reaches zero
// RULE14: bad operand or precondition forces internal reset
// RULE15: stop waits for timer and enable cleared
// RULE16: wake must outlast oscillator wait, else stop
// RULE17: pin wake detected without the clock
`default_nettype none

package standby_pkg;

    // ------------------------------------------------------------
    // halt operand low-bit codes
    // ------------------------------------------------------------
    localparam logic [2:0] OP_STOP_ALL_A = 3'h0;
    localparam logic [2:0] OP_STOP_ALL_B = 3'h3;
    localparam logic [2:0] OP_STOP_LOW = 3'h6;
    localparam logic [2:0] OP_HALT_TIMER = 3'h5;
    localparam int OP_SENSE_BIT = 3;

    // ------------------------------------------------------------
    // pin synchroniser layout: keys 0..3, sense 4..5, reset pin 6
    // ------------------------------------------------------------
    localparam int NUM_KEYS = 4;
    localparam int NUM_SYNC = 7;
    localparam int SYNC_SENSE_LO = 4;
    localparam int SYNC_RESET_PIN = 6;
    // reset pin is active low, so its clean level starts high
    localparam logic [6:0] SYNC_RESET_VAL = 7'h40;

    // ------------------------------------------------------------
    // oscillator wait timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int OSC_WAIT_US = 100;
    localparam int OSC_WAIT_CYCLES = OSC_WAIT_US * CLK_MHZ;
    localparam int WAIT_W = 12;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESET_CNT = 8'h08;
    localparam int CTRL_SENSE_LO = 0;
    localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
    localparam int STATUS_FLAG_BIT = 8;
    localparam int STATUS_WAKE_RST_BIT = 9;
    localparam int STATUS_OP_LO = 12;

    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_DRAIN = 5'h02,
        ST_STOP = 5'h04,
        ST_WAIT = 5'h08,
        ST_HALT = 5'h10
    } standby_state_t;

endpackage

`default_nettype wire

/* inc/pin_sync_if.sv */
// Purpose: carries raw pins, clean levels and wake mask between modules
// Assumes: one clock domain, pclk
// Notes:   wake_raw is level logic that needs no clock edge
`default_nettype none

interface pin_sync_if;
    logic [6:0] raw;       // pins as they arrive
    logic [6:0] wake_mask; // pins allowed to wake stop mode
    logic [6:0] clean;     // three-stage filtered levels
    logic wake_raw;        // unclocked wake level
    modport detector (input raw, input wake_mask, output clean, output wake_raw);
    modport user (output raw, output wake_mask, input clean, input wake_raw);
endinterface

`default_nettype wire

/* core/pin_wake_sync.sv */
// Purpose: filters wake pins and raises an unclocked wake level
// Assumes: pins are asynchronous to pclk
// Notes:   clean level moves once stages two and three agree
`default_nettype none

module pin_wake_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins in, levels out
    pin_sync_if.detector sync
);

    // ------------------------------------------------------------
    // unclocked wake
    // ------------------------------------------------------------
    // RULE17 clockless wake level
    // pure gates, so the oscillator can be restarted with no edge
    assign sync.wake_raw = |(sync.raw & sync.wake_mask);

    // ------------------------------------------------------------
    // per-pin filter
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < standby_pkg::NUM_SYNC; i++) begin : g_pin
            logic s1_reg; // only read by s2_reg
            logic s2_reg;
            logic s3_reg;
            logic clean_reg;
            // three stages; a change counts once two and three agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_reg <= standby_pkg::SYNC_RESET_VAL[i];
                    s2_reg <= standby_pkg::SYNC_RESET_VAL[i];
                    s3_reg <= standby_pkg::SYNC_RESET_VAL[i];
                    clean_reg <= standby_pkg::SYNC_RESET_VAL[i];
                end else begin
                    s1_reg <= sync.raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        clean_reg <= s3_reg;
                    end
                end
            end
            assign sync.clean[i] = clean_reg;
        end
    endgenerate

endmodule

`default_nettype wire

/* testbench/key_matrix_model.sv */
// Purpose: key matrix on the far side of the scan and key pins
// Assumes: a closed key joins every scan line to its key input
// Notes:   the press length is set by the bench, short or long
`default_nettype none

module key_matrix_model (
    // bench control
    input wire logic press,
    // matrix pins
    input wire logic [3:0] key_scan_lines,
    output logic [3:0] key_input_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // key closure
    // released keys fall to the pull-down level, never the last value
    assign key_input_pins = press ? key_scan_lines : 4'h0;
endmodule

`default_nettype wire

/* testbench/standby_asserts.sv */
// Purpose: port checks of the standby controller
// Assumes: one clock, presetn async active low
// Notes:   halt decode is judged only while cpu is running
`default_nettype none

module standby_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sequencer and pins
    input wire logic halt_req,
    input wire logic [3:0] halt_operand,
    input wire logic [3:0] key_scan_lines,
    input wire logic [3:0] key_input_pins,
    input wire logic timer_zero,
    // outputs watched
    input wire logic cpu_hold,
    input wire logic state_retain,
    input wire logic status_flag,
    input wire logic internal_reset,
    input wire logic timer_clear,
    input wire logic osc_stop,
    input wire logic osc_pins_low,
    input wire logic osc_wake_level
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] lo; // operand mode bits
    logic bad; // operand or precondition refused
    logic go; // halt seen while running
    assign lo = halt_operand[2:0];
    assign bad = !(lo inside {3'h0, 3'h3, 3'h5, 3'h6}) || (lo == 3'h6 && !key_scan_lines[0])
        || ((lo == 3'h0 || lo == 3'h3) && key_scan_lines != 4'hf);
    assign go = halt_req && !cpu_hold;
    a_stop_pins_low: assert property (osc_stop |-> osc_pins_low && cpu_hold)
        else $error("oscillator pins not low in stop");
    a_retain_hold: assert property (state_retain == cpu_hold)
        else $error("retain differs from hold");
    a_stop_timer_clr: assert property (osc_stop |-> timer_clear)
        else $error("timer not cleared in stop");
    a_bad_op_reset: assert property (go && bad |=> internal_reset && !cpu_hold)
        else $error("refused halt gave no reset");
    a_flag_no_entry: assert property (go && status_flag |=> !cpu_hold)
        else $error("standby entered with flag set");
    a_exit_sets_flag: assert property ($fell(cpu_hold) |-> ##[0:1] status_flag)
        else $error("flag not set on exit");
    a_halt_osc_on: assert property (go && !status_flag && lo == 3'h5 && !timer_zero
        |=> cpu_hold && !osc_stop [*2]) else $error("halt mode stopped oscillator");
    a_drain_first: assert property (go && !status_flag && halt_operand == 4'h0
        && key_scan_lines == 4'hf && key_input_pins == 4'h0 && !timer_zero
        |=> timer_clear && !osc_stop) else $error("stop entered with timer busy");
    a_wake_level: assert property (osc_stop && |key_input_pins |-> osc_wake_level)
        else $error("no clockless wake level");
endmodule

bind standby_mode_controller standby_asserts standby_asserts_i (.*);

`default_nettype wire

/* testbench/standby_mode_controller_tb_top.sv */
// Purpose: self-checking bench of the standby controller
// Assumes: 40 MHz pclk, sense pins idle low
// Notes:   outputs are read right after an edge, i.e. last cycle's values
`default_nettype none

module standby_mode_controller_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, cpu_hold, state_retain, status_flag, internal_reset;
    logic halt_req = 1'b0, flag_set_req = 1'b0, flag_clear_req = 1'b0, press = 1'b0;
    logic [3:0] halt_operand = 4'h0, key_scan_lines = 4'hf, key_input_pins;
    logic timer_zero = 1'b1, timer_output_enable = 1'b0, reset_pin_n = 1'b1;
    logic sense_pin_zero = 1'b0, sense_pin_one = 1'b0; // idle sense pins
    logic resume_next, resume_zero, timer_clear, osc_stop, osc_pins_low, osc_wake_level;
    logic [1:0] got_next = 2'h0; // resume_next pulses counted
    logic got_zero = 1'b0; // resume_zero pulse caught
    int err_total = 0, cmp_count = 0, n;
    typedef struct {logic [3:0] op, scan; logic pre, rst, flg;} row_t;
    // decode cases: operand, scan lines, flag before, reset, flag after
    row_t rows [10] = '{'{4'h1, 4'hf, 0, 1, 0}, '{4'h2, 4'hf, 0, 1, 0}, '{4'h4, 4'hf, 0, 1, 0},
        '{4'h7, 4'hf, 0, 1, 0}, '{4'h9, 4'hf, 1, 1, 1}, '{4'h0, 4'he, 0, 1, 0}, '{4'h3, 4'h7, 0, 1, 0},
        '{4'he, 4'he, 0, 1, 0}, '{4'h0, 4'hf, 1, 0, 0}, '{4'h6, 4'h1, 1, 0, 0}};

    standby_mode_controller standby_mode_controller_i (.*);
    key_matrix_model key_matrix_model_i (.press(press), .key_scan_lines(key_scan_lines),
        .key_input_pins(key_input_pins));

    initial forever #12.5 pclk = ~pclk;
    // catch one-cycle resume pulses
    always @(posedge pclk) begin
        if (resume_next === 1'b1) got_next <= got_next + 2'h1;
        if (resume_zero === 1'b1) got_zero <= 1'b1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb transfer, waits for pready; hang cut by watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic halt(input logic [3:0] op);
        halt_req <= 1'b1; halt_operand <= op;
        @(posedge pclk);
        halt_req <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fclr;
        flag_clear_req <= 1'b1;
        @(posedge pclk);
        flag_clear_req <= 1'b0;
    endtask
    task end_of_test;
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        end_of_test;
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h3);
        apb(1'b0, 8'h0c, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        foreach (rows[i]) begin
            flag_set_req <= rows[i].pre; flag_clear_req <= !rows[i].pre; key_scan_lines <= rows[i].scan;
            @(posedge pclk);
            flag_set_req <= 1'b0; flag_clear_req <= 1'b0;
            halt(rows[i].op);
            chk({cpu_hold, internal_reset}, {1'b0, rows[i].rst});
            @(posedge pclk);
            chk(status_flag, rows[i].flg);
        end
        key_scan_lines <= 4'hf; timer_zero <= 1'b0;
        fclr;
        halt(4'h5);
        chk({cpu_hold, osc_stop, state_retain}, 3'b101);
        timer_zero <= 1'b1;
        for (n = 0; n < 50 && cpu_hold !== 1'b0; n++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk({status_flag, got_next}, 3'b101);
        timer_zero <= 1'b0; timer_output_enable <= 1'b1;
        fclr;
        halt(4'h0);
        chk({timer_clear, osc_stop, cpu_hold}, 3'b101);
        timer_zero <= 1'b1; timer_output_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({osc_stop, osc_pins_low, timer_clear}, 3'b111);
        press <= 1'b1;
        @(posedge pclk);
        chk(osc_wake_level, 1'b1);
        repeat (100) @(posedge pclk);
        chk(osc_stop, 1'b0);
        press <= 1'b0;
        for (n = 0; n < 4100 && osc_stop !== 1'b1; n++) @(posedge pclk);
        chk({osc_stop, cpu_hold, got_next}, 4'b1101);
        press <= 1'b1;
        for (n = 0; n < 4200 && cpu_hold !== 1'b0; n++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk({status_flag, got_next, cpu_hold}, 4'b1100);
        fclr;
        repeat (6) @(posedge pclk);
        halt(4'h0);
        chk({cpu_hold, internal_reset}, 2'b00);
        @(posedge pclk);
        chk(status_flag, 1'b1);
        press <= 1'b0;
        repeat (6) @(posedge pclk);
        fclr;
        halt(4'h3);
        chk({cpu_hold, osc_stop}, 2'b11);
        reset_pin_n <= 1'b0;
        for (n = 0; n < 50 && cpu_hold !== 1'b0; n++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk({status_flag, got_zero}, 2'b11);
        reset_pin_n <= 1'b1;
        fclr;
        halt(4'h8);
        sense_pin_one <= 1'b1;
        for (n = 0; n < 4200 && cpu_hold !== 1'b0; n++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk({status_flag, got_next, cpu_hold}, 4'b1110);
        end_of_test;
    end
endmodule

`default_nettype wire
